// *** rtl/angle_regs_pkg.sv ***
// Package: register map, field positions, keys, reset values and timing of the angle sensor block
package angle_regs_pkg;
   // Register addresses (byte addresses of 16-bit words)
   localparam logic [7:0]  CMD_ADDR        = 8'h1E;
   localparam logic [7:0]  ANGLE_ADDR      = 8'h20;
   localparam logic [7:0]  COND_ADDR       = 8'h22;
   localparam logic [7:0]  FAULT_ADDR      = 8'h24;
   // Command word fields
   localparam int          CPU_CMD_HI      = 15;
   localparam int          CPU_CMD_LO      = 14;
   localparam int          FULL_RESET_BIT  = 13;
   localparam int          RESTART_BIT     = 12;
   localparam int          CLR_FLAGS_BIT   = 10;
   localparam int          CLR_EXT_BIT     = 9;
   localparam int          CLR_FAULT_BIT   = 8;
   localparam logic [7:0]  KEY_STATE_CLR   = 8'h46;
   localparam logic [7:0]  KEY_RESET       = 8'hB9;
   localparam logic [1:0]  CPU_GO_IDLE     = 2'h2;
   localparam logic [1:0]  CPU_GO_RUN      = 2'h3;
   // Angle register fields
   localparam int          TAG_BIT         = 15;
   localparam int          ERR_SUM_BIT     = 14;
   localparam int          FRESH_BIT       = 13;
   localparam int          PARITY_BIT      = 12;
   // Condition register fields and reset
   localparam logic [3:0]  COND_TAG        = 4'h8;
   localparam logic [3:0]  FAULT_TAG       = 4'hA;
   localparam logic [3:0]  PROG_BOOTED     = 4'h1;
   localparam logic [3:0]  PROG_BOOTING    = 4'h0;
   localparam logic [3:0]  PHASE_IDLE      = 4'h0;
   localparam logic [3:0]  PHASE_RUN       = 4'h1;
   localparam logic [15:0] COND_RESET      = 16'h8B11;
   localparam logic [15:0] CMD_RESET       = 16'h0000;
   // Timing at 250 MHz
   localparam int          CLK_MHZ         = 250;
   localparam int          IDLE_WAIT_US    = 128;
   localparam int          IDLE_WAIT_CYC   = IDLE_WAIT_US * CLK_MHZ;
   localparam int          BOOT_CYC        = 16;
   localparam int          IDLE_ENTRY_CYC  = 64;
   // Host port register offsets
   localparam logic [3:0]  HP_CMD          = 4'h0;
   localparam logic [3:0]  HP_STATUS       = 4'h1;
   localparam logic [3:0]  HP_ANGLE        = 4'h2;
   localparam logic [3:0]  HP_COND         = 4'h3;
   localparam logic [3:0]  HP_RDADDR       = 4'h4;
   localparam logic [3:0]  HP_RDDATA       = 4'h5;
   // Parity helper: value that makes a 16-bit word's ones count odd
   function automatic logic odd_fill(input logic [15:0] w);
      return ~(^w);
   endfunction
endpackage

// *** rtl/sensor_link_if.sv ***
// Interface: register-level link between the serial master and the sensor register bank
`timescale 1ns/100ps
interface sensor_link_if;
   logic        wr_stb;
   logic        rd_stb;
   logic [7:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        rvalid;
   modport sensor (input wr_stb, input rd_stb, input addr, input wdata,
                   output rdata, output rvalid);
   modport master (output wr_stb, output rd_stb, output addr, output wdata,
                   input rdata, input rvalid);
endinterface

// *** rtl/cmd_decode.sv ***
// Command word decoder: key check and strobe generation
`timescale 1ns/100ps
module cmd_decode (
   input  wire logic [15:0] word_i,
   input  wire logic        wr_i,
   output logic             go_idle_o,
   output logic             go_run_o,
   output logic             full_reset_o,
   output logic             restart_o,
   output logic             clr_flags_o,
   output logic             clr_ext_o,
   output logic             clr_fault_o
);
   logic key46;
   logic keyb9;
   logic [1:0] st;
   // Each command fires only with its own key in the same word
   always_comb begin
      key46        = wr_i && (word_i[7:0] == angle_regs_pkg::KEY_STATE_CLR);
      keyb9        = wr_i && (word_i[7:0] == angle_regs_pkg::KEY_RESET);
      st           = word_i[angle_regs_pkg::CPU_CMD_HI:angle_regs_pkg::CPU_CMD_LO];
      go_idle_o    = key46 && (st == angle_regs_pkg::CPU_GO_IDLE);
      go_run_o     = key46 && (st == angle_regs_pkg::CPU_GO_RUN);
      full_reset_o = keyb9 && word_i[angle_regs_pkg::FULL_RESET_BIT];
      restart_o    = keyb9 && word_i[angle_regs_pkg::RESTART_BIT];
      clr_flags_o  = key46 && word_i[angle_regs_pkg::CLR_FLAGS_BIT];
      clr_ext_o    = key46 && word_i[angle_regs_pkg::CLR_EXT_BIT];
      clr_fault_o  = key46 && word_i[angle_regs_pkg::CLR_FAULT_BIT];
   end
endmodule

// *** rtl/angle_sensor_regs.sv ***
// Sensor end: command, angle, condition and fault registers of the angle sensor
`timescale 1ns/100ps
module angle_sensor_regs #(
   parameter int IDLE_CYC = angle_regs_pkg::IDLE_ENTRY_CYC
) (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   sensor_link_if.sensor    link,
   input  wire logic        sample_stb_i,
   input  wire logic [11:0] sample_i,
   input  wire logic [11:0] fault_in_i,
   input  wire logic [11:0] fault_mask_i,
   input  wire logic        ext_fault_i,
   input  wire logic        loop_disable_opt_i,
   output logic             running_o,
   output logic             full_reset_o,
   output logic [7:0]       iface_pointer_o
);
   typedef enum logic [2:0] {
      CPU_BOOT = 3'b001,
      CPU_IDLE = 3'b010,
      CPU_RUN  = 3'b100
   } cpu_state_t;

   typedef struct packed {
      cpu_state_t  cpu;
      logic [15:0] cnt;
      logic        going_idle;
      logic [11:0] angle;
      logic        fresh;
      logic        por_flag;
      logic        soft_restart_flag;
      logic [11:0] faults;
      logic [11:0] faults_seen;
      logic        ext_fault;
      logic        ext_seen;
      logic [15:0] rdata;
      logic        rvalid;
      logic        full_reset;
      logic [7:0]  ptr;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   logic go_idle, go_run, do_full, do_restart, clr_flags, clr_ext, clr_fault;
   logic        err_sum;
   logic [15:0] angle_word;
   logic [15:0] cond_word;
   logic [15:0] fault_word;

   // Command bits never store: readback is key zero and strobes zero
   localparam logic [15:0] CMD_READBACK = angle_regs_pkg::CMD_RESET;

   // Keyed command strobes; only a fresh write can produce one
   cmd_decode u_dec (
      .word_i       (link.wdata),
      .wr_i         (link.wr_stb && link.addr == angle_regs_pkg::CMD_ADDR),
      .go_idle_o    (go_idle),
      .go_run_o     (go_run),
      .full_reset_o (do_full),
      .restart_o    (do_restart),
      .clr_flags_o  (clr_flags),
      .clr_ext_o    (clr_ext),
      .clr_fault_o  (clr_fault)
   );

   // Read-side views of the registers
   always_comb begin
      err_sum    = |(s_r.faults & ~fault_mask_i) || s_r.ext_fault;
      angle_word = {1'b0, err_sum, s_r.fresh, 1'b0, s_r.angle};
      angle_word[angle_regs_pkg::PARITY_BIT] = angle_regs_pkg::odd_fill(angle_word);
      cond_word  = {angle_regs_pkg::COND_TAG, s_r.por_flag, s_r.soft_restart_flag,
                    s_r.fresh, err_sum,
                    (s_r.cpu == CPU_BOOT) ? angle_regs_pkg::PROG_BOOTING
                                          : angle_regs_pkg::PROG_BOOTED,
                    (s_r.cpu == CPU_RUN) ? angle_regs_pkg::PHASE_RUN
                                         : angle_regs_pkg::PHASE_IDLE};
      fault_word = {angle_regs_pkg::FAULT_TAG, s_r.ext_fault, 3'h0,
                    (s_r.cpu != CPU_RUN), s_r.faults[6:0]};
   end

   // Next-state logic for the whole bank
   always_comb begin
      s_nxt            = s_r;
      s_nxt.rvalid     = link.rd_stb;
      s_nxt.full_reset = 1'b0;
      s_nxt.rdata      = 16'h0000;
      // Sticky faults; new events win over a clear
      if (clr_fault) begin
         s_nxt.faults = s_r.faults & ~s_r.faults_seen;
      end
      s_nxt.faults = s_nxt.faults | fault_in_i;
      if (clr_ext) begin
         s_nxt.ext_fault = s_r.ext_fault & ~s_r.ext_seen;
      end
      s_nxt.ext_fault = s_nxt.ext_fault | ext_fault_i;
      if (clr_flags) begin
         s_nxt.por_flag          = 1'b0;
         s_nxt.soft_restart_flag = 1'b0;
      end
      // Processor mode sequencing
      case (s_r.cpu)
         CPU_BOOT: begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
            if (s_r.cnt == 16'(angle_regs_pkg::BOOT_CYC - 1)) begin
               s_nxt.cpu = CPU_RUN;
               s_nxt.cnt = 16'h0000;
            end
         end
         CPU_RUN: begin
            // Angles load only in Run; an idle command stops them from the next cycle on, ahead of the delayed move to Idle
            if (sample_stb_i && !s_r.going_idle) begin
               s_nxt.angle = sample_i;
               s_nxt.fresh = 1'b1;
            end
            if (go_idle) begin
               s_nxt.going_idle = 1'b1;
            end
            if (s_r.going_idle) begin
               s_nxt.cnt = s_r.cnt + 16'h0001;
               if (s_r.cnt == 16'(IDLE_CYC - 1)) begin
                  s_nxt.cpu        = CPU_IDLE;
                  s_nxt.going_idle = 1'b0;
                  s_nxt.cnt        = 16'h0000;
               end
            end
         end
         CPU_IDLE: begin
            if (go_run) begin
               s_nxt.cpu = CPU_RUN;
            end
         end
         default: s_nxt.cpu = CPU_BOOT;
      endcase
      // Register reads; a read of the angle consumes the fresh flag
      if (link.rd_stb) begin
         case (link.addr)
            angle_regs_pkg::ANGLE_ADDR: begin
               s_nxt.rdata = angle_word;
               if (!(sample_stb_i && s_r.cpu == CPU_RUN && !s_r.going_idle)) begin
                  s_nxt.fresh = 1'b0;
               end
               s_nxt.ptr = loop_disable_opt_i ? 8'(angle_regs_pkg::COND_ADDR)
                                              : angle_regs_pkg::ANGLE_ADDR;
            end
            angle_regs_pkg::COND_ADDR: begin
               s_nxt.rdata = cond_word;
               s_nxt.ptr   = 8'(angle_regs_pkg::FAULT_ADDR);
            end
            angle_regs_pkg::FAULT_ADDR: begin
               s_nxt.rdata       = fault_word;
               s_nxt.faults_seen = s_r.faults;
               s_nxt.ext_seen    = s_r.ext_fault;
            end
            angle_regs_pkg::CMD_ADDR: begin
               s_nxt.rdata = CMD_READBACK;
            end
            default: s_nxt.rdata = 16'h0000;
         endcase
      end
      // Restart keeps sticky faults; full reset also clears them
      if (do_restart || do_full) begin
         s_nxt.cpu               = CPU_BOOT;
         s_nxt.cnt               = 16'h0000;
         s_nxt.going_idle        = 1'b0;
         s_nxt.soft_restart_flag = 1'b1;
      end
      if (do_full) begin
         s_nxt.faults     = 12'h000;
         s_nxt.ext_fault  = 1'b0;
         s_nxt.full_reset = 1'b1;
      end
   end

   // Single state register; reset matches documented defaults
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r                   <= '0;
         s_r.cpu               <= CPU_BOOT;
         s_r.fresh             <= 1'b1;
         s_r.faults            <= 12'h000;
         s_r.ext_fault         <= 1'b1;
         s_r.por_flag          <= 1'b1;
         s_r.soft_restart_flag <= 1'b0;
         s_r.ptr               <= angle_regs_pkg::ANGLE_ADDR;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.rdata      = s_r.rdata;
   assign link.rvalid     = s_r.rvalid;
   assign running_o       = s_r.cpu[2]; // One-hot Run bit, no decode after the register
   assign full_reset_o    = s_r.full_reset;
   assign iface_pointer_o = s_r.ptr;
endmodule

// *** rtl/sensor_master.sv ***
// Master end: software port driving the sensor register link
`timescale 1ns/100ps
module sensor_master (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   sensor_link_if.master    link,
   input  wire logic [3:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [15:0]      rdata_o
);
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic [7:0]  rd_addr;
      logic [15:0] last;
      logic        busy;
      logic [15:0] rdata;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   // Software orders become single link strobes; readback of status too
   always_comb begin
      s_nxt       = s_r;
      s_nxt.wr    = 1'b0;
      s_nxt.rd    = 1'b0;
      s_nxt.rdata = 16'h0000;
      if (link.rvalid) begin
         s_nxt.last = link.rdata;
         s_nxt.busy = 1'b0;
      end
      if (wr_i) begin
         case (addr_i)
            angle_regs_pkg::HP_CMD: begin
               s_nxt.wr    = 1'b1;
               s_nxt.addr  = angle_regs_pkg::CMD_ADDR;
               s_nxt.wdata = wdata_i;
            end
            angle_regs_pkg::HP_RDADDR: begin
               s_nxt.rd      = 1'b1;
               s_nxt.busy    = 1'b1;
               s_nxt.rd_addr = wdata_i[7:0];
               s_nxt.addr    = wdata_i[7:0];
            end
            default: s_nxt.wr = 1'b0;
         endcase
      end
      if (rd_i) begin
         case (addr_i)
            angle_regs_pkg::HP_STATUS: s_nxt.rdata = {15'h0000, s_r.busy};
            angle_regs_pkg::HP_RDADDR: s_nxt.rdata = {8'h00, s_r.rd_addr};
            angle_regs_pkg::HP_RDDATA: s_nxt.rdata = s_r.last;
            default:                   s_nxt.rdata = 16'h0000;
         endcase
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.wr_stb = s_r.wr;
   assign link.rd_stb = s_r.rd;
   assign link.addr   = s_r.addr;
   assign link.wdata  = s_r.wdata;
   assign rdata_o     = s_r.rdata;
endmodule

// *** tb/angle_sensor_assertions.sv ***
// Checker: link timing, register contents and command effects of the sensor register bank
`timescale 1ns/100ps
module angle_sensor_assertions #(
   parameter int IDLE_CYC = angle_regs_pkg::IDLE_ENTRY_CYC
) (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   input  wire logic [7:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic [15:0] rdata,
   input  wire logic        rvalid,
   input  wire logic        running_o,
   input  wire logic        full_reset_o
);
   localparam int IDLE_MAX = IDLE_CYC + 8;
   localparam int FALL_MAX = IDLE_CYC + 40;
   logic        keyed_full;
   logic        keyed_stop;
   logic [2:0]  full_hist_r;
   logic [15:0] since_r;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   // Keyed writes that may stop angle processing
   assign keyed_full = wr_stb && addr == angle_regs_pkg::CMD_ADDR && wdata[13]
                       && wdata[7:0] == angle_regs_pkg::KEY_RESET;
   assign keyed_stop = keyed_full || (wr_stb && addr == angle_regs_pkg::CMD_ADDR
                       && ((wdata[12] && wdata[7:0] == angle_regs_pkg::KEY_RESET)
                       || (wdata[15:14] == angle_regs_pkg::CPU_GO_IDLE
                       && wdata[7:0] == angle_regs_pkg::KEY_STATE_CLR)));

   // History of keyed writes; saturating so long runs never wrap back into range
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         full_hist_r <= 3'h0;
         since_r     <= 16'h0000;
      end else begin
         full_hist_r <= {full_hist_r[1:0], keyed_full};
         if (keyed_stop) begin
            since_r <= 16'h0000;
         end else if (since_r != 16'hFFFF) begin
            since_r <= since_r + 16'h0001;
         end
      end
   end

   sequence s_angle_read;
      rd_stb && addr == angle_regs_pkg::ANGLE_ADDR;
   endsequence
   sequence s_go_idle;
      wr_stb && addr == angle_regs_pkg::CMD_ADDR && wdata[15:14] == angle_regs_pkg::CPU_GO_IDLE
      && wdata[7:0] == angle_regs_pkg::KEY_STATE_CLR;
   endsequence
   sequence s_full_reset;
      wr_stb && keyed_full;
   endsequence

   property p_answer;
      rd_stb |=> rvalid;
   endproperty
   property p_no_stray;
      rvalid |-> $past(rd_stb);
   endproperty
   property p_tag_zero;
      s_angle_read |=> rvalid && !rdata[15];
   endproperty
   property p_parity;
      s_angle_read |=> ^rdata;
   endproperty
   property p_cond_tag;
      rd_stb && addr == angle_regs_pkg::COND_ADDR |=> rdata[15:12] == angle_regs_pkg::COND_TAG;
   endproperty
   property p_fault_tag;
      rd_stb && addr == angle_regs_pkg::FAULT_ADDR |=> rdata[15:12] == angle_regs_pkg::FAULT_TAG;
   endproperty
   property p_key_hidden;
      rd_stb && addr == angle_regs_pkg::CMD_ADDR |=> rdata[7:0] == 8'h00;
   endproperty
   property p_go_idle;
      s_go_idle |-> ##[1:IDLE_MAX] !running_o;
   endproperty
   property p_full_reset;
      s_full_reset |-> ##[1:3] full_reset_o;
   endproperty
   property p_full_cause;
      full_reset_o |-> full_hist_r != 3'h0;
   endproperty
   property p_fall_cause;
      $fell(running_o) |-> since_r <= FALL_MAX;
   endproperty

   a_answer:     assert property (p_answer) else $error("read without answer");
   a_no_stray:   assert property (p_no_stray) else $error("answer without read");
   a_tag_zero:   assert property (p_tag_zero) else $error("angle top bit set");
   a_parity:     assert property (p_parity) else $error("angle parity even");
   a_cond_tag:   assert property (p_cond_tag) else $error("condition tag wrong");
   a_fault_tag:  assert property (p_fault_tag) else $error("fault tag wrong");
   a_key_hidden: assert property (p_key_hidden) else $error("key field visible");
   a_go_idle:    assert property (p_go_idle) else $error("idle not reached");
   a_full_reset: assert property (p_full_reset) else $error("full reset missing");
   a_full_cause: assert property (p_full_cause) else $error("unkeyed full reset");
   a_fall_cause: assert property (p_fall_cause) else $error("run left unasked");
endmodule

// *** tb/angle_sensor_control_status_regs_test.sv ***
// Testbench: host port and sensor inputs driven against both ends of the register link
`timescale 1ns/100ps
module angle_sensor_control_status_regs_test;
   localparam int IDLE_CYC = angle_regs_pkg::IDLE_ENTRY_CYC;
   typedef struct packed {logic [15:0] word; logic [15:0] mask; logic [15:0] exp;} cmd_row_t;
   logic        sys_clk_i;
   logic        rst_i;
   logic [3:0]  addr_i;
   logic [15:0] wdata_i;
   logic        wr_i;
   logic        rd_i;
   logic [15:0] rdata_o;
   logic        sample_stb_i;
   logic [11:0] sample_i;
   logic [11:0] fault_in_i;
   logic [11:0] fault_mask_i;
   logic        ext_fault_i;
   logic        loop_disable_opt_i;
   logic        running_o;
   logic        full_reset_o;
   logic [7:0]  iface_pointer_o;
   logic [15:0] d;
   int          n_errors = 0;
   int          n_compared = 0;
   int          cyc = 0;
   cmd_row_t    rows [9];

   sensor_link_if sensor_link_if_i ();
   angle_sensor_regs #(.IDLE_CYC(IDLE_CYC)) angle_sensor_regs_i (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(sensor_link_if_i.sensor),
      .sample_stb_i(sample_stb_i), .sample_i(sample_i), .fault_in_i(fault_in_i),
      .fault_mask_i(fault_mask_i), .ext_fault_i(ext_fault_i),
      .loop_disable_opt_i(loop_disable_opt_i), .running_o(running_o),
      .full_reset_o(full_reset_o), .iface_pointer_o(iface_pointer_o));
   sensor_master sensor_master_i (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(sensor_link_if_i.master), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
   angle_sensor_assertions #(.IDLE_CYC(IDLE_CYC)) angle_sensor_assertions_i (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .wr_stb(sensor_link_if_i.wr_stb),
      .rd_stb(sensor_link_if_i.rd_stb), .addr(sensor_link_if_i.addr),
      .wdata(sensor_link_if_i.wdata), .rdata(sensor_link_if_i.rdata),
      .rvalid(sensor_link_if_i.rvalid), .running_o(running_o), .full_reset_o(full_reset_o));

   // 250 MHz clock
   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   // Hang guard: whole run needs well under this many cycles
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (n_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Host write: one cycle strobe, dropped after the taking edge
   task automatic hw(input logic [3:0] a, input logic [15:0] v);
      @(posedge sys_clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= v;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic hr(input logic [3:0] a, output logic [15:0] v);
      @(posedge sys_clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask

   // Sensor read: start it, then fetch the data once the link answer has landed
   task automatic sr(input logic [7:0] a, output logic [15:0] v);
      hw(angle_regs_pkg::HP_RDADDR, {8'h00, a});
      @(posedge sys_clk_i);
      hr(angle_regs_pkg::HP_RDDATA, v);
   endtask

   task automatic pulse(input logic [11:0] smp, input logic [11:0] flt, input logic ext);
      @(posedge sys_clk_i);
      sample_stb_i <= |smp;
      sample_i     <= smp;
      fault_in_i   <= flt;
      ext_fault_i  <= ext;
      @(posedge sys_clk_i);
      sample_stb_i <= 1'b0;
      fault_in_i   <= 12'h000;
      ext_fault_i  <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
   endtask

   function automatic logic [15:0] odd_word(input logic [15:0] w);
      return w | {3'b000, ~(^w), 12'h000};
   endfunction

   initial begin
      rst_i = 1'b1;
      {addr_i, wdata_i, wr_i, rd_i, sample_stb_i, sample_i} = '0;
      {fault_in_i, fault_mask_i, ext_fault_i, loop_disable_opt_i} = '0;
      // Command word, mask over condition register, expected masked value
      rows = '{'{16'h8046, 16'h000F, 16'h0000}, '{16'hC0B9, 16'h000F, 16'h0000},
               '{16'hC046, 16'h000F, 16'h0001}, '{16'h4046, 16'h000F, 16'h0001},
               '{16'h8047, 16'h000F, 16'h0001}, '{16'h10B9, 16'h0CFF, 16'h0C11},
               '{16'h04B9, 16'h0C00, 16'h0C00}, '{16'h0446, 16'h0C00, 16'h0000},
               '{16'h20B9, 16'h0CFF, 16'h0411}};
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (30) @(posedge sys_clk_i);
      sr(angle_regs_pkg::COND_ADDR, d);
      chk("condition after boot", angle_regs_pkg::COND_RESET, d);
      sr(angle_regs_pkg::ANGLE_ADDR, d);
      chk("angle flags after reset", 16'h6000, d & 16'hE000);
      // Command table
      foreach (rows[i]) begin
         hw(angle_regs_pkg::HP_CMD, rows[i].word);
         repeat (IDLE_CYC + 40) @(posedge sys_clk_i);
         sr(angle_regs_pkg::COND_ADDR, d);
         chk("condition after command", rows[i].exp, d & rows[i].mask);
         sr(angle_regs_pkg::CMD_ADDR, d);
         chk("key field", 16'h0000, {8'h00, d[7:0]});
      end
      // Clear faults seen so far, then a fresh sample
      sr(angle_regs_pkg::FAULT_ADDR, d);
      hw(angle_regs_pkg::HP_CMD, 16'h0346);
      pulse(12'hABC, 12'h000, 1'b0);
      sr(angle_regs_pkg::ANGLE_ADDR, d);
      chk("fresh angle", odd_word(16'h2ABC), d);
      chk("pointer looped", {8'h00, angle_regs_pkg::ANGLE_ADDR}, {8'h00, iface_pointer_o});
      sr(angle_regs_pkg::ANGLE_ADDR, d);
      chk("angle after read", odd_word(16'h0ABC), d);
      @(posedge sys_clk_i);
      loop_disable_opt_i <= 1'b1;
      sr(angle_regs_pkg::ANGLE_ADDR, d);
      chk("pointer no loop", {8'h00, angle_regs_pkg::COND_ADDR}, {8'h00, iface_pointer_o});
      // Sticky fault, masking, wrong-key clear, keyed clear
      pulse(12'h000, 12'h008, 1'b0);
      sr(angle_regs_pkg::ANGLE_ADDR, d);
      chk("sticky fault", 16'h0001, {15'h0000, d[14]});
      @(posedge sys_clk_i);
      fault_mask_i <= 12'h008;
      sr(angle_regs_pkg::ANGLE_ADDR, d);
      chk("masked fault", 16'h0000, {15'h0000, d[14]});
      @(posedge sys_clk_i);
      fault_mask_i <= 12'h000;
      sr(angle_regs_pkg::FAULT_ADDR, d);
      hw(angle_regs_pkg::HP_CMD, 16'h01B9);
      sr(angle_regs_pkg::ANGLE_ADDR, d);
      chk("fault kept on wrong key", 16'h0001, {15'h0000, d[14]});
      hw(angle_regs_pkg::HP_CMD, 16'h0146);
      sr(angle_regs_pkg::ANGLE_ADDR, d);
      chk("fault cleared", 16'h0000, {15'h0000, d[14]});
      pulse(12'h000, 12'h000, 1'b1);
      sr(angle_regs_pkg::FAULT_ADDR, d);
      chk("extended fault seen", 16'h0001, {15'h0000, d[11]});
      hw(angle_regs_pkg::HP_CMD, 16'h0246);
      sr(angle_regs_pkg::ANGLE_ADDR, d);
      chk("extended fault cleared", 16'h0000, {15'h0000, d[14]});
      // Idle holds the last angle even when a sample arrives
      hw(angle_regs_pkg::HP_CMD, 16'h8046);
      repeat (IDLE_CYC + 40) @(posedge sys_clk_i);
      pulse(12'h123, 12'h000, 1'b0);
      sr(angle_regs_pkg::ANGLE_ADDR, d);
      chk("idle angle frozen", 16'h0ABC, {4'h0, d[11:0]});
      // Unmapped host place reads zero
      hw(4'hE, 16'hFFFF);
      hr(4'hF, d);
      chk("unmapped read", 16'h0000, d);
      // Busy shows while a link read is in flight, then drops on its answer
      hw(angle_regs_pkg::HP_RDADDR, {8'h00, angle_regs_pkg::COND_ADDR});
      hr(angle_regs_pkg::HP_STATUS, d);
      chk("busy in flight", 16'h0001, d);
      hr(angle_regs_pkg::HP_STATUS, d);
      chk("busy after answer", 16'h0000, d);
      hr(angle_regs_pkg::HP_RDADDR, d);
      chk("read address", {8'h00, angle_regs_pkg::COND_ADDR}, d);
      // Reset in mid-run: history flag returns and the bank reboots
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (30) @(posedge sys_clk_i);
      sr(angle_regs_pkg::COND_ADDR, d);
      chk("condition after second reset", angle_regs_pkg::COND_RESET, d);
      report_and_stop();
   end
endmodule
